/* File: design/tccr_defs.svh */
// offsets, field positions, reset values for the capture/compare timer
// assumes word-addressed cpu port with big-endian byte lanes (hi lane = even byte)
`ifndef TCCR_DEFS_SVH
`define TCCR_DEFS_SVH
// ==========================================
// word offsets (channel words at ch*4 + n)
`define TCCR_W_CTL      2'h0
`define TCCR_W_CNT      2'h1
`define TCCR_W_GRA      2'h2
`define TCCR_W_GRB      2'h3
`define TCCR_W_START    4'hC
`define TCCR_W_MODE     4'hD
`define TCCR_W_OVF      4'hE
// ==========================================
// field positions
`define TCCR_PHASE_BIT  6
`define TCCR_CCLR_HI    6
`define TCCR_EDGE_HI    4
`define TCCR_PS_HI      2
// ==========================================
// reset values
`define TCCR_CTL_RST    8'h80
`define TCCR_IOC_RST    8'h88
`define TCCR_OLP_RST    8'hC0
`define TCCR_GR_RST     16'hFFFF
`define TCCR_OLP_RD     8'hFF
`endif

/* File: design/tccr_pkg.sv */
// types for the capture/compare timer
// assumes tccr_defs.svh supplies the numeric constants
package tccr_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } tccr_bus_req_type;
endpackage : tccr_pkg

/* File: design/tccr_timer.sv */
// three-channel 16-bit capture/compare timer with cpu register port
// assumes cpu port synchronous to sys_clk, pins and clock inputs pass a synchroniser; rdata valid the cycle after rd
`include "tccr_defs.svh"
module tccr_timer
  import tccr_pkg::*;
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // cpu register port
  input  wire tccr_bus_req_type bus_req,
  output logic [15:0]           rdata,
  // external clock inputs a..d
  input  wire logic [3:0]       ext_clock_in,
  // capture/compare pins per channel
  input  wire logic [2:0]       compare_capture_pin_a_in,
  output logic [2:0]            compare_capture_pin_a_out,
  output logic [2:0]            compare_capture_pin_a_oe,
  input  wire logic [2:0]       compare_capture_pin_b_in,
  output logic [2:0]            compare_capture_pin_b_out,
  output logic [2:0]            compare_capture_pin_b_oe
);
  // ==========================================
  // state
  logic [7:0]  ctl_reg [3], ctl_next [3];
  logic [7:0]  ioc_reg [3], ioc_next [3];
  logic [15:0] cnt_reg [3], cnt_next [3];
  logic [15:0] gra_reg [3], gra_next [3];
  logic [15:0] grb_reg [3], grb_next [3];
  logic [2:0]  start_reg, start_next, sync_reg, sync_next, pwm_reg, pwm_next;
  logic        phase_reg, phase_next;
  logic [7:0]  olp_reg, olp_next;
  logic [2:0]  ovf_reg, ovf_next, out_a_reg, out_a_next, out_b_reg, out_b_next;
  logic [15:0] rdata_reg, rdata_next;
  // synchroniser stages: s1 feeds s2 only, edges from s2/s3
  logic [9:0]  in_s1_reg, in_s2_reg, in_s3_reg;
  logic [2:0]  div_reg, div_next;
  // combinational events
  logic [2:0]  tick, up, match_a, match_b, cap_a, cap_b, clr;
  logic [3:0]  ext_rise, ext_fall;
  logic [2:0]  pa_rise, pa_fall, pb_rise, pb_fall;
  logic [3:0]  int_tick;
  logic        sync_clr, a_edge, b_edge, cnt_wr_sync;
  logic [15:0] cnt_wr_val;
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
                                        input logic [1:0] be);
    merge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction : merge
  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    edge_hit = sel[1] ? (r | f) : (sel[0] ? f : r);
  endfunction : edge_hit
  // compare mode: func[2]==0, or pwm forces it
  function automatic logic is_cmp(input logic [2:0] f, input logic pwm);
    is_cmp = pwm | ~f[2];
  endfunction : is_cmp
  // ==========================================
  // input edges
  always_comb begin
    ext_rise = in_s2_reg[3:0] & ~in_s3_reg[3:0];
    ext_fall = ~in_s2_reg[3:0] & in_s3_reg[3:0];
    pa_rise  = in_s2_reg[6:4] & ~in_s3_reg[6:4];
    pa_fall  = ~in_s2_reg[6:4] & in_s3_reg[6:4];
    pb_rise  = in_s2_reg[9:7] & ~in_s3_reg[9:7];
    pb_fall  = ~in_s2_reg[9:7] & in_s3_reg[9:7];
    div_next = div_reg + 3'h1;
    // falling edge of each prescaled clock, one-cycle enable
    int_tick = {div_reg == 3'h7, div_reg[1:0] == 2'h3, div_reg[0], 1'b1};
    a_edge   = ext_rise[0] | ext_fall[0];
    b_edge   = ext_rise[1] | ext_fall[1];
  end
  // ==========================================
  // per-channel events
  always_comb begin
    sync_clr = 1'b0;
    for (int c = 0; c < 3; c++) begin
      up[c] = 1'b1;
      if (c == 2 && phase_reg) begin
        // channel 2 phase mode: prescaler and edge bits unused
        tick[c] = start_reg[c] & (a_edge | b_edge);
        up[c]   = a_edge ? (in_s2_reg[0] != in_s2_reg[1])
                         : (in_s2_reg[1] == in_s2_reg[0]);
      end else if (!ctl_reg[c][`TCCR_PS_HI]) begin
        tick[c] = start_reg[c] & int_tick[ctl_reg[c][1:0]];
      end else begin
        tick[c] = start_reg[c] & edge_hit(ctl_reg[c][4:3], ext_rise[ctl_reg[c][1:0]],
                                          ext_fall[ctl_reg[c][1:0]]);
      end
      // match fires as the counter leaves the matching value
      match_a[c] = is_cmp(ioc_reg[c][2:0], pwm_reg[c]) & tick[c] & (cnt_reg[c] == gra_reg[c]);
      match_b[c] = is_cmp(ioc_reg[c][6:4], pwm_reg[c]) & tick[c] & (cnt_reg[c] == grb_reg[c]);
      cap_a[c]   = ~is_cmp(ioc_reg[c][2:0], pwm_reg[c])
                   & edge_hit(ioc_reg[c][1:0], pa_rise[c], pa_fall[c]);
      cap_b[c]   = ~is_cmp(ioc_reg[c][6:4], pwm_reg[c])
                   & edge_hit(ioc_reg[c][5:4], pb_rise[c], pb_fall[c]);
      case (ctl_reg[c][6:5])
        2'h1:    clr[c] = match_a[c] | cap_a[c];
        2'h2:    clr[c] = match_b[c] | cap_b[c];
        default: clr[c] = 1'b0;
      endcase
      if (sync_reg[c] && clr[c]) sync_clr = 1'b1;
    end
    for (int c = 0; c < 3; c++) begin
      if (ctl_reg[c][6:5] == 2'h3 && sync_reg[c]) clr[c] = sync_clr;
    end
  end
  // ==========================================
  // register and counter next state
  always_comb begin
    start_next  = start_reg;
    sync_next   = sync_reg;
    pwm_next    = pwm_reg;
    phase_next  = phase_reg;
    olp_next    = olp_reg;
    ovf_next    = ovf_reg;
    out_a_next  = out_a_reg;
    out_b_next  = out_b_reg;
    rdata_next  = rdata_reg;
    cnt_wr_sync = 1'b0;
    cnt_wr_val  = 16'h0000;
    for (int c = 0; c < 3; c++) begin
      ctl_next[c] = ctl_reg[c];
      ioc_next[c] = ioc_reg[c];
      gra_next[c] = gra_reg[c];
      grb_next[c] = grb_reg[c];
      cnt_next[c] = cnt_reg[c];
      if (clr[c]) begin
        cnt_next[c] = 16'h0000;
      end else if (tick[c]) begin
        cnt_next[c] = up[c] ? cnt_reg[c] + 16'h0001 : cnt_reg[c] - 16'h0001;
        ovf_next[c] = ovf_next[c] | (up[c] ? &cnt_reg[c] : ~|cnt_reg[c]);
      end
      if (cap_a[c]) gra_next[c] = cnt_reg[c];
      if (cap_b[c]) grb_next[c] = cnt_reg[c];
      // compare outputs; channel 2 toggle becomes drive 1
      if (pwm_reg[c]) begin
        if (match_b[c]) out_a_next[c] = 1'b0;
        else if (match_a[c]) out_a_next[c] = 1'b1;
      end else if (match_a[c]) begin
        case (ioc_reg[c][1:0])
          2'h1:    out_a_next[c] = 1'b0;
          2'h2:    out_a_next[c] = 1'b1;
          2'h3:    out_a_next[c] = (c == 2) ? 1'b1 : ~out_a_reg[c];
          default: out_a_next[c] = out_a_reg[c];
        endcase
      end
      if (!pwm_reg[c] && match_b[c]) begin
        case (ioc_reg[c][5:4])
          2'h1:    out_b_next[c] = 1'b0;
          2'h2:    out_b_next[c] = 1'b1;
          2'h3:    out_b_next[c] = (c == 2) ? 1'b1 : ~out_b_reg[c];
          default: out_b_next[c] = out_b_reg[c];
        endcase
      end
    end
    // cpu writes win over counting on the same register, except an overflow flag set this cycle
    if (bus_req.wr) begin
      if (bus_req.addr[3:2] != 2'h3) begin
        for (int c = 0; c < 3; c++) begin
          if (bus_req.addr[3:2] == 2'(c)) begin
            case (bus_req.addr[1:0])
              `TCCR_W_CTL: begin
                // paired 8-bit registers: a word write is two byte writes
                if (bus_req.be[1]) ctl_next[c] = bus_req.wdata[15:8] | 8'h80;
                if (bus_req.be[0]) ioc_next[c] = bus_req.wdata[7:0] | 8'h88;
              end
              `TCCR_W_CNT: begin
                cnt_next[c] = merge(cnt_reg[c], bus_req.wdata, bus_req.be);
                cnt_wr_sync = sync_reg[c];
                cnt_wr_val  = cnt_next[c];
              end
              `TCCR_W_GRA: gra_next[c] = merge(gra_reg[c], bus_req.wdata, bus_req.be);
              default:     grb_next[c] = merge(grb_reg[c], bus_req.wdata, bus_req.be);
            endcase
          end
        end
      end else begin
        case (bus_req.addr)
          `TCCR_W_START: begin
            if (bus_req.be[1]) start_next = bus_req.wdata[10:8];
            if (bus_req.be[0]) sync_next = bus_req.wdata[2:0];
          end
          `TCCR_W_MODE: begin
            if (bus_req.be[1]) begin
              pwm_next   = bus_req.wdata[10:8];
              phase_next = bus_req.wdata[8+`TCCR_PHASE_BIT];
            end
            if (bus_req.be[0]) begin
              olp_next = {2'b11, bus_req.wdata[5:0]};
              for (int c = 0; c < 3; c++) begin
                if (!start_reg[c]) begin
                  out_a_next[c] = bus_req.wdata[2*c];
                  out_b_next[c] = bus_req.wdata[2*c+1];
                end
              end
            end
          end
          `TCCR_W_OVF: begin
            // only zero clears; a flag set this cycle survives
            if (bus_req.be[1]) ovf_next = ovf_next & (bus_req.wdata[10:8] | ovf_next & ~ovf_reg);
          end
          default: ;
        endcase
      end
    end
    if (cnt_wr_sync) begin
      for (int c = 0; c < 3; c++) begin
        if (sync_reg[c]) cnt_next[c] = cnt_wr_val;
      end
    end
    if (bus_req.rd) begin
      case (bus_req.addr)
        `TCCR_W_START: rdata_next = {5'h1F, start_reg, 5'h00, sync_reg};
        `TCCR_W_MODE:  rdata_next = {1'b1, phase_reg, 3'h7, pwm_reg, `TCCR_OLP_RD};
        `TCCR_W_OVF:   rdata_next = {5'h11, ovf_reg, 8'h00};
        4'hF:          rdata_next = 16'h0000;
        default: begin
          case (bus_req.addr[1:0])
            `TCCR_W_CTL: rdata_next = {ctl_reg[bus_req.addr[3:2]], ioc_reg[bus_req.addr[3:2]]};
            `TCCR_W_CNT: rdata_next = cnt_reg[bus_req.addr[3:2]];
            `TCCR_W_GRA: rdata_next = gra_reg[bus_req.addr[3:2]];
            default:     rdata_next = grb_reg[bus_req.addr[3:2]];
          endcase
        end
      endcase
    end
  end
  // ==========================================
  // registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < 3; c++) begin
        ctl_reg[c] <= `TCCR_CTL_RST;
        ioc_reg[c] <= `TCCR_IOC_RST;
        cnt_reg[c] <= 16'h0000;
        gra_reg[c] <= `TCCR_GR_RST;
        grb_reg[c] <= `TCCR_GR_RST;
      end
      start_reg <= 3'h0;
      sync_reg  <= 3'h0;
      pwm_reg   <= 3'h0;
      phase_reg <= 1'b0;
      olp_reg   <= `TCCR_OLP_RST;
      ovf_reg   <= 3'h0;
      out_a_reg <= 3'h0;
      out_b_reg <= 3'h0;
      rdata_reg <= 16'h0000;
      div_reg   <= 3'h0;
      in_s1_reg <= 10'h000;
      in_s2_reg <= 10'h000;
      in_s3_reg <= 10'h000;
    end else begin
      ctl_reg   <= ctl_next;
      ioc_reg   <= ioc_next;
      cnt_reg   <= cnt_next;
      gra_reg   <= gra_next;
      grb_reg   <= grb_next;
      start_reg <= start_next;
      sync_reg  <= sync_next;
      pwm_reg   <= pwm_next;
      phase_reg <= phase_next;
      olp_reg   <= olp_next;
      ovf_reg   <= ovf_next;
      out_a_reg <= out_a_next;
      out_b_reg <= out_b_next;
      rdata_reg <= rdata_next;
      div_reg   <= div_next;
      in_s1_reg <= {compare_capture_pin_b_in, compare_capture_pin_a_in, ext_clock_in};
      in_s2_reg <= in_s1_reg;
      in_s3_reg <= in_s2_reg;
    end
  end
  // ==========================================
  // outputs: drive while the register works as compare
  always_comb begin
    rdata                     = rdata_reg;
    compare_capture_pin_a_out = out_a_reg;
    compare_capture_pin_b_out = out_b_reg;
    for (int c = 0; c < 3; c++) begin
      compare_capture_pin_a_oe[c] = is_cmp(ioc_reg[c][2:0], pwm_reg[c]);
      compare_capture_pin_b_oe[c] = is_cmp(ioc_reg[c][6:4], pwm_reg[c]);
    end
  end
  // ==========================================
  // checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  olp_read_ones_a: assert property (bus_req.rd && bus_req.addr == `TCCR_W_MODE
    |=> rdata[7:0] == 8'hFF) else $error("level register read not all ones");
  olp_locked_a: assert property (start_reg[0] && bus_req.wr && !match_a[0]
    && !match_b[0] && bus_req.addr == `TCCR_W_MODE
    |=> out_a_reg[0] == $past(out_a_reg[0])) else $error("level changed while running");
  ovf_wrap_a: assert property (tick[0] && !clr[0] && cnt_reg[0] == 16'hFFFF && !bus_req.wr
    |=> ovf_reg[0] && cnt_reg[0] == 16'h0000) else $error("wrap did not set overflow");
  sync_preset_a: assert property (bus_req.wr && bus_req.addr == 4'h1 && bus_req.be == 2'h3
    && sync_reg[0] && sync_reg[1] |=> cnt_reg[1] == cnt_reg[0]) else $error("sync preset mismatch");
  pwm_set_a: assert property (pwm_reg[0] && match_a[0] && !match_b[0] && !bus_req.wr
    |=> compare_capture_pin_a_out[0]) else $error("pwm did not set on match a");
  ch2_no_toggle_a: assert property (!pwm_reg[2] && ioc_reg[2][2:0] == 3'h3 && match_a[2]
    && !bus_req.wr |=> out_a_reg[2]) else $error("channel 2 toggled");
  halt_hold_a: assert property (!start_reg[0] && !bus_req.wr && !clr[0]
    |=> cnt_reg[0] == $past(cnt_reg[0])) else $error("stopped counter moved");
  phase_up_a: assert property (phase_reg && start_reg[2] && ext_rise[0] && !in_s2_reg[1]
    && !clr[2] && !bus_req.wr |=> cnt_reg[2] == $past(cnt_reg[2]) + 16'h0001)
    else $error("phase count not up");
  clk_count_a: assert property (start_reg[0] && ctl_reg[0] == 8'h80 && !bus_req.wr
    |=> cnt_reg[0] == $past(cnt_reg[0]) + 16'h0001) else $error("system clock count missed");
  cov_ovf_c:   cover property (ovf_reg[0] && !$past(ovf_reg[0]));
  cov_cap_c:   cover property (cap_b[1]);
  cov_pwm_c:   cover property (pwm_reg[0] && match_b[0]);
  cov_phase_c: cover property (phase_reg && tick[2] && !up[2]);
endmodule : tccr_timer

/* File: bench/tccr_cpu_model.sv */
// cpu-side model of the timer's register port
// assumes the bench owns sys_clk; requests change at falling edges only
module tccr_cpu_model
  import tccr_pkg::*;
(
  // clock
  input  wire logic        sys_clk,
  // register port
  output tccr_bus_req_type bus_req,
  input  wire logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bus_req = '0;
  // ==========================================
  // one write, held over exactly one taking edge
  task automatic wr(input logic [3:0] a, input logic [1:0] be, input logic [15:0] d);
    @(negedge sys_clk);
    bus_req = '{wr: 1'b1, rd: 1'b0, addr: a, be: be, wdata: d};
    @(negedge sys_clk);
    bus_req = '0;
  endtask : wr
  // ==========================================
  // rdata stands until the next read, so sample late
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    bus_req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 2'b11, wdata: 16'h0000};
    @(negedge sys_clk);
    bus_req = '0;
    @(negedge sys_clk);
    d = rdata;
  endtask : rd
endmodule : tccr_cpu_model

/* File: bench/test_three_channel_capture_compare_timer.sv */
// self-checking bench for the three-channel capture/compare timer
// assumes tccr_defs.svh word map; pins not driven by the timer follow *_drv
`include "tccr_defs.svh"
module test_three_channel_capture_compare_timer
  import tccr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             sys_clk = 1'b0;
  logic             rst_n = 1'b0;
  tccr_bus_req_type bus_req;
  logic [15:0]      rdata, v, w, g;
  logic [3:0]       ext_clock_in = 4'h0;
  logic [2:0]       a_in, a_out, a_oe, b_in, b_out, b_oe;
  logic [2:0]       a_drv = 3'h0, b_drv = 3'h0;
  int               err_count = 0, n_checks = 0, cyc = 0, n;
  // ==========================================
  // wire level: timer wins where it drives
  assign a_in = (a_oe & a_out) | (~a_oe & a_drv);
  assign b_in = (b_oe & b_out) | (~b_oe & b_drv);
  always #10 sys_clk = ~sys_clk;
  tccr_cpu_model cpu_u (.sys_clk(sys_clk), .bus_req(bus_req), .rdata(rdata));
  tccr_timer dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
    .ext_clock_in(ext_clock_in),
    .compare_capture_pin_a_in(a_in), .compare_capture_pin_a_out(a_out),
    .compare_capture_pin_a_oe(a_oe), .compare_capture_pin_b_in(b_in),
    .compare_capture_pin_b_out(b_out), .compare_capture_pin_b_oe(b_oe));
  // ==========================================
  // checking and closing
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    if (err_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  // whole run is under a thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("Error %0t: run hung", $time);
      give_verdict();
    end
  end
  function automatic logic [3:0] ra(input int ch, input logic [1:0] wd);
    return {ch[1:0], wd};
  endfunction : ra
  task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    cpu_u.rd(a, d);
    chk(d, exp);
  endtask : rchk
  task automatic cfg(input int ch, input logic [7:0] ctl, input logic [7:0] io);
    cpu_u.wr(ra(ch, `TCCR_W_CTL), 2'b11, {ctl, io});
  endtask : cfg
  task automatic run(input logic [2:0] s);
    cpu_u.wr(`TCCR_W_START, 2'b10, {5'h00, s, 8'h00});
  endtask : run
  task automatic pins(input logic [15:0] exp);
    chk({12'h000, b_out[2], b_out[0], a_out[2], a_out[0]}, exp);
  endtask : pins
  // ==========================================
  // scenarios
  task automatic t_reset();
    for (int ch = 0; ch < 3; ch++) begin
      rchk(ra(ch, `TCCR_W_CTL), {`TCCR_CTL_RST, `TCCR_IOC_RST});
      rchk(ra(ch, `TCCR_W_CNT), 16'h0000);
      rchk(ra(ch, `TCCR_W_GRB), `TCCR_GR_RST);
    end
    // mode byte: reserved bits read one, pwm and phase off
    rchk(`TCCR_W_MODE, {8'hB8, `TCCR_OLP_RD});
    rchk(4'hF, 16'h0000);
    chk({10'h000, b_out, a_out}, 16'h0000);
  endtask : t_reset
  task automatic t_regs();
    cfg(1, 8'h25, 8'h66);
    rchk(ra(1, `TCCR_W_CTL), 16'hA5EE);
    cpu_u.wr(ra(0, `TCCR_W_CNT), 2'b11, 16'h1234);
    cpu_u.wr(ra(0, `TCCR_W_CNT), 2'b10, 16'hAB00);
    rchk(ra(0, `TCCR_W_CNT), 16'hAB34);
    cpu_u.wr(ra(0, `TCCR_W_CNT), 2'b01, 16'h00CD);
    rchk(ra(0, `TCCR_W_CNT), 16'hABCD);
  endtask : t_regs
  task automatic t_level();
    logic [7:0] l;
    for (int i = 0; i < 6; i++) begin
      l = 8'h01 << i;
      cpu_u.wr(`TCCR_W_MODE, 2'b01, {8'h00, l});
      @(negedge sys_clk);
      chk({10'h000, b_out, a_out}, {10'h000, l[5], l[3], l[1], l[4], l[2], l[0]});
    end
    cpu_u.wr(`TCCR_W_MODE, 2'b01, 16'h0001);
    run(3'b001);
    cpu_u.wr(`TCCR_W_MODE, 2'b01, 16'h0000);
    @(negedge sys_clk);
    chk({15'h0000, a_out[0]}, 16'h0001);
    run(3'b000);
  endtask : t_level
  task automatic t_prescale();
    run(3'b001);
    for (int p = 0; p < 4; p++) begin
      cfg(0, {5'h00, 3'(p)}, 8'h00);
      cpu_u.rd(ra(0, `TCCR_W_CNT), v);
      repeat (29) @(negedge sys_clk);
      cpu_u.rd(ra(0, `TCCR_W_CNT), w);
      chk(w - v, 16'h0020 >> p);
    end
  endtask : t_prescale
  task automatic t_ext();
    logic [1:0] e, s;
    for (int i = 0; i < 7; i++) begin
      e = (i < 4) ? 2'(i) : 2'b00;
      s = (i < 4) ? 2'b00 : 2'(i - 3);
      cfg(0, {3'b000, e, 1'b1, s}, 8'h00);
      cpu_u.rd(ra(0, `TCCR_W_CNT), v);
      // pulses kept wide: narrow ones are lost by the synchroniser
      repeat (4) begin
        @(negedge sys_clk) ext_clock_in[s] = 1'b1;
        repeat (4) @(negedge sys_clk);
        ext_clock_in[s] = 1'b0;
        repeat (4) @(negedge sys_clk);
      end
      cpu_u.rd(ra(0, `TCCR_W_CNT), w);
      chk(w - v, e[1] ? 16'h0008 : 16'h0004);
    end
    run(3'b000);
  endtask : t_ext
  task automatic t_compare();
    cfg(0, 8'h00, 8'h13);
    cfg(2, 8'h00, 8'h23);
    for (int ch = 0; ch < 3; ch += 2) begin
      cpu_u.wr(ra(ch, `TCCR_W_GRA), 2'b11, 16'h0003);
      cpu_u.wr(ra(ch, `TCCR_W_GRB), 2'b11, 16'h0005);
      cpu_u.wr(ra(ch, `TCCR_W_CNT), 2'b11, 16'h0000);
    end
    cpu_u.wr(`TCCR_W_MODE, 2'b01, 16'h0013);
    @(negedge sys_clk);
    pins(16'h0007);
    chk({10'h000, b_oe, a_oe}, 16'h002D);
    run(3'b101);
    repeat (20) @(negedge sys_clk);
    run(3'b000);
    pins(16'h000A);
  endtask : t_compare
  task automatic t_capture();
    cfg(1, 8'h00, 8'h40);
    cpu_u.wr(ra(1, `TCCR_W_CNT), 2'b11, 16'h0000);
    run(3'b010);
    cpu_u.rd(ra(1, `TCCR_W_CNT), v);
    @(negedge sys_clk) b_drv[1] = 1'b1;
    repeat (8) @(negedge sys_clk);
    cpu_u.rd(ra(1, `TCCR_W_CNT), w);
    cpu_u.rd(ra(1, `TCCR_W_GRB), g);
    chk({15'h0000, g > v && g < w}, 16'h0001);
    chk({15'h0000, b_oe[1]}, 16'h0000);
    @(negedge sys_clk) b_drv[1] = 1'b0;
    repeat (8) @(negedge sys_clk);
    rchk(ra(1, `TCCR_W_GRB), g);
    run(3'b000);
  endtask : t_capture
  task automatic t_sync();
    cpu_u.rd(ra(2, `TCCR_W_CNT), g);
    cpu_u.wr(`TCCR_W_START, 2'b11, 16'h0003);
    cfg(0, 8'h20, 8'h00);
    cfg(1, 8'h60, 8'h00);
    cpu_u.wr(ra(0, `TCCR_W_GRA), 2'b11, 16'h0508);
    cpu_u.wr(ra(0, `TCCR_W_CNT), 2'b11, 16'h0500);
    rchk(ra(1, `TCCR_W_CNT), 16'h0500);
    rchk(ra(2, `TCCR_W_CNT), g);
    cpu_u.wr(`TCCR_W_START, 2'b11, 16'h0303);
    repeat (30) @(negedge sys_clk);
    cpu_u.wr(`TCCR_W_START, 2'b11, 16'h0003);
    cpu_u.rd(ra(0, `TCCR_W_CNT), v);
    cpu_u.rd(ra(1, `TCCR_W_CNT), w);
    chk(w, v);
    // 32 ticks: 8 up to the match value, one clear, then 23 more
    chk(w, 16'h0017);
    cpu_u.wr(`TCCR_W_START, 2'b11, 16'h0000);
  endtask : t_sync
  task automatic t_pwm();
    cpu_u.wr(`TCCR_W_MODE, 2'b10, 16'h0100);
    cfg(0, 8'h40, 8'h44);
    cpu_u.wr(ra(0, `TCCR_W_GRA), 2'b11, 16'h0004);
    cpu_u.wr(ra(0, `TCCR_W_GRB), 2'b11, 16'h000C);
    cpu_u.wr(ra(0, `TCCR_W_CNT), 2'b11, 16'h0000);
    run(3'b001);
    chk({15'h0000, a_oe[0]}, 16'h0001);
    repeat (20) @(negedge sys_clk);
    n = 0;
    // two whole periods of 13 counts: high 8 of each
    repeat (26) begin
      @(negedge sys_clk);
      n += a_out[0];
    end
    chk(16'(n), 16'h0010);
    run(3'b000);
    cpu_u.wr(`TCCR_W_MODE, 2'b10, 16'h0000);
  endtask : t_pwm
  task automatic t_ovf();
    cfg(0, 8'h00, 8'h00);
    cpu_u.wr(ra(0, `TCCR_W_CNT), 2'b11, 16'hFFF0);
    run(3'b001);
    repeat (30) @(negedge sys_clk);
    run(3'b000);
    cpu_u.rd(`TCCR_W_OVF, v);
    chk({15'h0000, v[8]}, 16'h0001);
    cpu_u.wr(`TCCR_W_OVF, 2'b10, 16'h0000);
    cpu_u.rd(`TCCR_W_OVF, v);
    chk({15'h0000, v[8]}, 16'h0000);
  endtask : t_ovf
  task automatic quad(input logic rev);
    repeat (4) begin
      @(negedge sys_clk) ext_clock_in[rev] = ~ext_clock_in[rev];
      repeat (4) @(negedge sys_clk);
      ext_clock_in[!rev] = ~ext_clock_in[!rev];
      repeat (4) @(negedge sys_clk);
    end
  endtask : quad
  task automatic t_phase();
    cfg(2, 8'h1F, 8'h00);
    cpu_u.wr(`TCCR_W_MODE, 2'b10, 16'h4000);
    run(3'b100);
    cpu_u.rd(ra(2, `TCCR_W_CNT), v);
    quad(1'b0);
    cpu_u.rd(ra(2, `TCCR_W_CNT), w);
    chk(w - v, 16'h0008);
    quad(1'b1);
    rchk(ra(2, `TCCR_W_CNT), v);
    run(3'b000);
  endtask : t_phase
  // ==========================================
  // main sequence
  initial begin
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    t_reset();
    t_regs();
    t_level();
    t_prescale();
    t_ext();
    t_compare();
    t_capture();
    t_sync();
    t_pwm();
    t_ovf();
    t_phase();
    give_verdict();
  end
endmodule : test_three_channel_capture_compare_timer
